// *** hdl/ufb_frame_baud_cfg.v ***
// serial port frame, mode and baud configuration registers on AHB-Lite,
// with decoded settings for the serial engines and a LIN auto-baud
// window check.
// assumes engine strobes come from logic on CLOCK_IN; single-word
// AHB-Lite transfers from one master.
// reserved codes are stored as written; decode treats them as off or 8.
// no protection around rate or order changes: engines see them at once.
//
// How it works
// R1 - multiproc_addr_mode set to 1 turns multiprocessor mode on, 0 off.
// R2 - comm_mode_select picks async 0, sync 1, infrared 2, host SPI 3.
// R3 - with mode 3 the frame register shows bit order at 2, phase at 1.
// R4 - parity_select: 0 off, 1 reserved, 2 even, 3 odd.
// R5 - stop_bit_select gives one stop bit at 0, two at 1, tx only.
// R6 - char_size_select codes 0..3 give 5..8 bits, 6 and 7 give 9 bits.
// R7 - code 6 is low byte first, code 7 high byte first for 9 bits.
// R8 - in host SPI, bit_order_select 0 is MSB first, 1 is LSB first.
// R9 - a bit order change during a transfer spoils both directions.
// R10 - clock_phase_select 0 samples leading edge, 1 trailing edge.
// R11 - the 16-bit prescaler is split in a low and a high byte register.
// R12 - any prescaler write reloads the baud generator at once.
// R13 - a baud change mid-transfer may corrupt it, with no protection.
// R14 - window field gives 32 +/- 6, 5, 7 or 8 samples per bit pair.
// R15 - the check counts samples per bit pair, 32 for equal rates.
// R16 - receiver_mode_select 3 selects LIN constrained auto-baud.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`include "ufb_defs.vh"

module ufb_frame_baud_cfg #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input wire CLOCK_IN,
  input wire RESET_IN,
  // AHB-Lite slave
  input wire HSEL_IN,
  input wire [ADDR_W-1:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire HWRITE_IN,
  input wire [2:0] HSIZE_IN,
  input wire [31:0] HWDATA_IN,
  input wire HREADY_IN,
  output wire HREADYOUT_OUT,
  output wire HRESP_OUT,
  output wire [31:0] HRDATA_OUT,
  // engine status
  input wire XFER_BUSY_IN,
  input wire PAIR_COUNT_VALID_IN,
  input wire [7:0] PAIR_COUNT_IN,
  // decoded settings
  output wire MULTIPROC_MODE_OUT,
  output wire [1:0] COMM_MODE_OUT,
  output wire HOST_SPI_MODE_OUT,
  output wire INFRARED_MODE_OUT,
  output wire PARITY_ENABLE_OUT,
  output wire PARITY_ODD_OUT,
  output wire TWO_STOP_BITS_OUT,
  output wire [3:0] DATA_BITS_OUT,
  output wire NINE_BIT_HIGH_FIRST_OUT,
  output wire SPI_LSB_FIRST_OUT,
  output wire SPI_SAMPLE_TRAILING_OUT,
  output wire [15:0] BAUD_PRESCALER_OUT,
  output wire LIN_AUTOBAUD_OUT,
  // event strobes
  output wire BAUD_RELOAD_OUT,
  output wire ORDER_ABORT_OUT,
  // auto-baud window result
  output wire WINDOW_CHECK_DONE_OUT,
  output wire WINDOW_OK_OUT
);

  // register contents
  reg multiproc_addr_mode_q;
  reg [1:0] receiver_mode_select_q;
  reg [1:0] comm_mode_select_q;
  reg [1:0] par_q;
  reg stop_q;
  reg [2:0] chs_q;
  reg order_q;
  reg phase_q;
  reg [15:0] baud_q;
  reg [1:0] abw_q;

  // bus state
  reg wr_pend_q;
  reg rd_pend_q;
  reg [ADDR_W-1:0] addr_q;
  reg [31:0] rdata_q;
  reg reload_q;
  reg abort_q;
  reg chk_done_q;
  reg chk_ok_q;

  // register byte addresses, zero-extended to the bus address width
  wire [ADDR_W-1:0] a_rx =
    {{(ADDR_W-10){1'b0}}, `UFB_IDX_RX_CTRL, 2'b00};
  wire [ADDR_W-1:0] a_frame =
    {{(ADDR_W-10){1'b0}}, `UFB_IDX_FRAME, 2'b00};
  wire [ADDR_W-1:0] a_blo =
    {{(ADDR_W-10){1'b0}}, `UFB_IDX_BAUD_LO, 2'b00};
  wire [ADDR_W-1:0] a_bhi =
    {{(ADDR_W-10){1'b0}}, `UFB_IDX_BAUD_HI, 2'b00};
  wire [ADDR_W-1:0] a_win =
    {{(ADDR_W-10){1'b0}}, `UFB_IDX_WINDOW, 2'b00};

  wire take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  wire spi_now = (comm_mode_select_q == `UFB_COMM_MODE_SELECT_SPI);
  wire [7:0] wb = HWDATA_IN[7:0];
  wire [1:0] wmode = wb[`UFB_COMM_MODE_SELECT_MSB:`UFB_COMM_MODE_SELECT_LSB];
  wire wmode_spi = (wmode == `UFB_COMM_MODE_SELECT_SPI);

  // address phase capture; reads take one wait state so that
  // read data always comes from a flop
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (rd_pend_q) begin
      // wait state: the bus is stalled, nothing new is taken
      rd_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take & HWRITE_IN;
      rd_pend_q <= take & ~HWRITE_IN;
    end
  end

  // address held for the data phase that follows
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      addr_q <= {ADDR_W{1'b0}};
    end else if (take & ~rd_pend_q) begin
      addr_q <= HADDR_IN;
    end
  end

  // per-register hits on the captured address
  wire hit_rx = (addr_q == a_rx);
  wire hit_frame = (addr_q == a_frame);
  wire hit_blo = (addr_q == a_blo);
  wire hit_bhi = (addr_q == a_bhi);
  wire hit_win = (addr_q == a_win);

  // write strobes, each high for the one data-phase cycle
  wire wen_rx = wr_pend_q & hit_rx;
  wire wen_frame = wr_pend_q & hit_frame;
  wire wen_blo = wr_pend_q & hit_blo;
  wire wen_bhi = wr_pend_q & hit_bhi;
  wire wen_win = wr_pend_q & hit_win;

  // receiver control
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      {receiver_mode_select_q, multiproc_addr_mode_q} <= `UFB_RST_RX_CTRL;
    end else if (wen_rx) begin
      multiproc_addr_mode_q <= wb[`UFB_MULTIPROC_ADDR_MODE_BIT]; // [R1]
      receiver_mode_select_q <= wb[`UFB_RECEIVER_MODE_SELECT_MSB:`UFB_RECEIVER_MODE_SELECT_LSB]; // [R16]
    end
  end

  // mode field, written in either layout
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      comm_mode_select_q <= `UFB_RST_COMM_MODE_SELECT;
    end else if (wen_frame) begin
      comm_mode_select_q <= wmode; // [R2]
    end
  end

  // host SPI layout; only filled when the written mode is host SPI
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      order_q <= `UFB_RST_ORDER;
      phase_q <= `UFB_RST_PHASE;
    end else if (wen_frame & wmode_spi) begin
      order_q <= wb[`UFB_ORDER_BIT]; // [R3] [R8]
      phase_q <= wb[`UFB_PHASE_BIT]; // [R10]
    end
  end

  // frame layout; kept untouched while host SPI bits are written
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      par_q <= `UFB_RST_PAR;
      stop_q <= `UFB_RST_STOP;
      chs_q <= `UFB_RST_CHS;
    end else if (wen_frame & ~wmode_spi) begin
      par_q <= wb[`UFB_PAR_MSB:`UFB_PAR_LSB]; // [R4]
      stop_q <= wb[`UFB_STOP_BIT]; // [R5]
      chs_q <= wb[`UFB_CHS_MSB:`UFB_CHS_LSB]; // [R6] [R7]
    end
  end

  // prescaler bytes, each written on its own
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      baud_q <= `UFB_RST_BAUD;
    end else begin
      if (wen_blo) begin
        baud_q[7:0] <= wb; // [R11]
      end
      if (wen_bhi) begin
        baud_q[15:8] <= wb; // [R11]
      end
    end
  end

  // auto-baud window size
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      abw_q <= `UFB_RST_ABW;
    end else if (wen_win) begin
      abw_q <= wb[`UFB_ABW_MSB:`UFB_ABW_LSB]; // [R14]
    end
  end

  // one-cycle event strobes for the serial engines
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      reload_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      // reload even mid-frame; corrupting it is accepted
      reload_q <= wen_blo | wen_bhi; // [R12] [R13]
      // order flip mid-transfer: tell engines both ways are lost
      abort_q <= wen_frame & wmode_spi & XFER_BUSY_IN & spi_now &
                 (wb[`UFB_ORDER_BIT] != order_q); // [R9]
    end
  end

  // read mux, loaded during the wait state
  reg [7:0] rd_byte;
  always @* begin
    // unmapped reads return zero
    rd_byte = 8'h00;
    if (addr_q == a_rx) begin
      rd_byte = {5'h00, receiver_mode_select_q, multiproc_addr_mode_q};
    end else if (addr_q == a_frame) begin
      if (spi_now) begin
        rd_byte = {comm_mode_select_q, 3'h0, order_q, phase_q, 1'b0}; // [R3]
      end else begin
        rd_byte = {comm_mode_select_q, par_q, stop_q, chs_q}; // [R3]
      end
    end else if (addr_q == a_blo) begin
      rd_byte = baud_q[7:0];
    end else if (addr_q == a_bhi) begin
      rd_byte = baud_q[15:8];
    end else if (addr_q == a_win) begin
      rd_byte = {abw_q, 6'h00};
    end
  end

  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign HREADYOUT_OUT = ~rd_pend_q;
  // every transfer ends OKAY; unmapped writes are dropped
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_q;

  // decoded settings
  reg [3:0] data_bits;
  always @* begin
    case (chs_q)
      `UFB_CHS_5: data_bits = 4'h5;
      `UFB_CHS_6: data_bits = 4'h6;
      `UFB_CHS_7: data_bits = 4'h7;
      `UFB_CHS_8: data_bits = 4'h8;
      `UFB_CHS_9L: data_bits = 4'h9;
      `UFB_CHS_9H: data_bits = 4'h9;
      // reserved codes fall back to eight bits
      default: data_bits = 4'h8;
    endcase
  end

  assign MULTIPROC_MODE_OUT = multiproc_addr_mode_q; // [R1]
  assign COMM_MODE_OUT = comm_mode_select_q; // [R2]
  assign HOST_SPI_MODE_OUT = spi_now; // [R2]
  assign INFRARED_MODE_OUT = (comm_mode_select_q == `UFB_COMM_MODE_SELECT_IR); // [R2]
  // reserved parity code leaves parity off
  assign PARITY_ENABLE_OUT = (par_q == `UFB_PAR_EVEN) |
                             (par_q == `UFB_PAR_ODD); // [R4]
  assign PARITY_ODD_OUT = (par_q == `UFB_PAR_ODD); // [R4]
  assign TWO_STOP_BITS_OUT = stop_q; // [R5]
  assign DATA_BITS_OUT = data_bits; // [R6]
  assign NINE_BIT_HIGH_FIRST_OUT = (chs_q == `UFB_CHS_9H); // [R7]
  assign SPI_LSB_FIRST_OUT = order_q; // [R8]
  assign SPI_SAMPLE_TRAILING_OUT = phase_q; // [R10]
  assign BAUD_PRESCALER_OUT = baud_q; // [R11]
  assign LIN_AUTOBAUD_OUT = (receiver_mode_select_q == `UFB_RECEIVER_MODE_SELECT_LIN); // [R16]
  assign BAUD_RELOAD_OUT = reload_q;
  assign ORDER_ABORT_OUT = abort_q;

  // auto-baud window check
  // tolerance per window code
  reg [7:0] tol;
  always @* begin
    case (abw_q)
      2'h0: tol = `UFB_TOL_W0;
      2'h1: tol = `UFB_TOL_W1;
      2'h2: tol = `UFB_TOL_W2;
      default: tol = `UFB_TOL_W3;
    endcase
  end

  // two bits at sixteen samples each; the doubled value fits 8 bits
  wire [8:0] nominal_w = {`UFB_SAMPLES_PER_BIT, 1'b0};
  wire [7:0] nominal = nominal_w[7:0]; // [R15]
  wire [7:0] lo_lim = nominal - tol; // [R14]
  wire [7:0] hi_lim = nominal + tol; // [R14]

  // a count is judged only in LIN constrained auto-baud
  wire count_take = PAIR_COUNT_VALID_IN & LIN_AUTOBAUD_OUT; // [R16]
  wire above_lo = (PAIR_COUNT_IN >= lo_lim);
  wire below_hi = (PAIR_COUNT_IN <= hi_lim);
  wire in_window = above_lo & below_hi; // [R15]

  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      chk_done_q <= 1'b0;
    end else begin
      chk_done_q <= count_take; // [R16]
    end
  end

  // result stands until the next judged count
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      chk_ok_q <= 1'b0;
    end else if (count_take) begin
      chk_ok_q <= in_window; // [R14] [R15]
    end
  end

  assign WINDOW_CHECK_DONE_OUT = chk_done_q;
  assign WINDOW_OK_OUT = chk_ok_q;

endmodule // ufb_frame_baud_cfg

// *** hdl/ufb_defs.vh ***
// register map, field positions and reset values of the frame and baud
// configuration block; definitions only
`ifndef UFB_DEFS_VH
`define UFB_DEFS_VH

// register indices; byte address is four times the index
`define UFB_IDX_RX_CTRL 8'h06
`define UFB_IDX_FRAME 8'h07
`define UFB_IDX_BAUD_LO 8'h08
`define UFB_IDX_BAUD_HI 8'h09
`define UFB_IDX_WINDOW 8'h0A

// receiver control fields
`define UFB_MULTIPROC_ADDR_MODE_BIT 0
`define UFB_RECEIVER_MODE_SELECT_LSB 1
`define UFB_RECEIVER_MODE_SELECT_MSB 2
`define UFB_RECEIVER_MODE_SELECT_LIN 2'h3

// frame format control fields
`define UFB_COMM_MODE_SELECT_LSB 6
`define UFB_COMM_MODE_SELECT_MSB 7
`define UFB_PAR_LSB 4
`define UFB_PAR_MSB 5
`define UFB_STOP_BIT 3
`define UFB_CHS_LSB 0
`define UFB_CHS_MSB 2
`define UFB_ORDER_BIT 2
`define UFB_PHASE_BIT 1

// communication modes
`define UFB_COMM_MODE_SELECT_ASYNC 2'h0
`define UFB_COMM_MODE_SELECT_SYNC 2'h1
`define UFB_COMM_MODE_SELECT_IR 2'h2
`define UFB_COMM_MODE_SELECT_SPI 2'h3

// parity codes
`define UFB_PAR_OFF 2'h0
`define UFB_PAR_EVEN 2'h2
`define UFB_PAR_ODD 2'h3

// character size codes
`define UFB_CHS_5 3'h0
`define UFB_CHS_6 3'h1
`define UFB_CHS_7 3'h2
`define UFB_CHS_8 3'h3
`define UFB_CHS_9L 3'h6
`define UFB_CHS_9H 3'h7

// auto-baud window field
`define UFB_ABW_LSB 6
`define UFB_ABW_MSB 7
`define UFB_SAMPLES_PER_BIT 8'h10
`define UFB_TOL_W0 8'h06
`define UFB_TOL_W1 8'h05
`define UFB_TOL_W2 8'h07
`define UFB_TOL_W3 8'h08

// reset values
`define UFB_RST_RX_CTRL 3'h0
`define UFB_RST_COMM_MODE_SELECT 2'h0
`define UFB_RST_PAR 2'h0
`define UFB_RST_STOP 1'h0
`define UFB_RST_CHS 3'h3
`define UFB_RST_ORDER 1'h0
`define UFB_RST_PHASE 1'h0
`define UFB_RST_BAUD 16'h0000
`define UFB_RST_ABW 2'h0

`endif

// *** sim/ufb_cfg_props.sv ***
// assertions on the ports of the frame and baud configuration block
// bound into every instance; one clock, async active-high reset
`timescale 1ns/100ps
module ufb_cfg_props #(
  parameter ADDR_W = 12
) (
  // clock, reset and bus
  input wire CLOCK_IN, RESET_IN, HSEL_IN, HWRITE_IN, HREADY_IN,
  input wire [ADDR_W-1:0] HADDR_IN,
  input wire [1:0] HTRANS_IN,
  input wire [31:0] HWDATA_IN,
  // engine status and decoded settings
  input wire PAIR_COUNT_VALID_IN, LIN_AUTOBAUD_OUT, HOST_SPI_MODE_OUT,
  input wire [7:0] PAIR_COUNT_IN,
  input wire [1:0] COMM_MODE_OUT,
  input wire PARITY_ENABLE_OUT, PARITY_ODD_OUT, NINE_BIT_HIGH_FIRST_OUT,
  input wire [3:0] DATA_BITS_OUT,
  input wire [15:0] BAUD_PRESCALER_OUT,
  input wire BAUD_RELOAD_OUT, WINDOW_CHECK_DONE_OUT, WINDOW_OK_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  reg wr_q;
  reg [ADDR_W-1:0] addr_q;
  // address kept only while ready, so a read wait cannot smear it
  always @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_q <= 1'b0;
      addr_q <= {ADDR_W{1'b0}};
    end else if (HREADY_IN) begin
      wr_q <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
      addr_q <= HADDR_IN;
    end
  end
  wire wr_lo = wr_q && HREADY_IN && addr_q == 'h20;
  wire wr_hi = wr_q && HREADY_IN && addr_q == 'h24;
  wire take = PAIR_COUNT_VALID_IN && LIN_AUTOBAUD_OUT;
  AST_SPI: assert property (HOST_SPI_MODE_OUT == &COMM_MODE_OUT)
    else $error("host spi decode wrong");
  AST_PAR: assert property (PARITY_ODD_OUT |-> PARITY_ENABLE_OUT)
    else $error("odd parity without parity");
  AST_BITS: assert property (DATA_BITS_OUT inside {[5:9]})
    else $error("data bits out of range");
  AST_NINE: assert property (
    NINE_BIT_HIGH_FIRST_OUT |-> DATA_BITS_OUT == 9)
    else $error("high first without nine bits");
  AST_RELOAD: assert property (wr_lo || wr_hi |=> BAUD_RELOAD_OUT)
    else $error("baud write without reload");
  AST_BLO: assert property (
    wr_lo |=> BAUD_PRESCALER_OUT[7:0] == $past(HWDATA_IN[7:0]))
    else $error("baud low byte wrong");
  AST_BHI: assert property (
    wr_hi |=> BAUD_PRESCALER_OUT[15:8] == $past(HWDATA_IN[7:0]))
    else $error("baud high byte wrong");
  AST_DONE: assert property (WINDOW_CHECK_DONE_OUT |-> $past(take))
    else $error("window check without lin count");
  AST_OK32: assert property (
    take && PAIR_COUNT_IN == 8'h20 |=>
    WINDOW_CHECK_DONE_OUT && WINDOW_OK_OUT)
    else $error("nominal count not accepted");
  cover property (BAUD_RELOAD_OUT);
  cover property (WINDOW_CHECK_DONE_OUT && !WINDOW_OK_OUT);
  cover property (HOST_SPI_MODE_OUT);
endmodule // ufb_cfg_props
bind ufb_frame_baud_cfg ufb_cfg_props #(.ADDR_W(ADDR_W)) i_props (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .HSEL_IN(HSEL_IN),
  .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HADDR_IN(HADDR_IN),
  .HTRANS_IN(HTRANS_IN), .HWDATA_IN(HWDATA_IN),
  .PAIR_COUNT_VALID_IN(PAIR_COUNT_VALID_IN),
  .LIN_AUTOBAUD_OUT(LIN_AUTOBAUD_OUT),
  .HOST_SPI_MODE_OUT(HOST_SPI_MODE_OUT), .PAIR_COUNT_IN(PAIR_COUNT_IN),
  .COMM_MODE_OUT(COMM_MODE_OUT), .PARITY_ENABLE_OUT(PARITY_ENABLE_OUT),
  .PARITY_ODD_OUT(PARITY_ODD_OUT),
  .NINE_BIT_HIGH_FIRST_OUT(NINE_BIT_HIGH_FIRST_OUT),
  .DATA_BITS_OUT(DATA_BITS_OUT), .BAUD_PRESCALER_OUT(BAUD_PRESCALER_OUT),
  .BAUD_RELOAD_OUT(BAUD_RELOAD_OUT),
  .WINDOW_CHECK_DONE_OUT(WINDOW_CHECK_DONE_OUT),
  .WINDOW_OK_OUT(WINDOW_OK_OUT));

// *** sim/ufb_peer_model.sv ***
// serial peer side: engine busy level and bit-pair sample counts
// driven through tasks on the block's clock
`timescale 1ns/100ps
module ufb_peer_model (
  // clock
  input wire clk_in,
  // engine status
  output reg busy_out,
  output reg valid_out,
  output reg [7:0] count_out
);
  initial begin
    busy_out = 1'b0;
    valid_out = 1'b0;
    count_out = 8'hA5;
  end
  // count shows inverted after its strobe, never a stale value
  task send(input [7:0] c);
    begin
      @(posedge clk_in);
      valid_out <= 1'b1;
      count_out <= c;
      @(posedge clk_in);
      valid_out <= 1'b0;
      count_out <= ~c;
    end
  endtask
  task set_busy(input b);
    begin
      @(posedge clk_in);
      busy_out <= b;
    end
  endtask
endmodule // ufb_peer_model

// *** sim/ufb_frame_baud_cfg_test.sv ***
// bench of the frame and baud configuration block
// AHB-Lite master tasks; peer model drives the engine status
`timescale 1ns/100ps
module ufb_frame_baud_cfg_test;
  localparam RX = 12'h018, FR = 12'h01C, BL = 12'h020, BH = 12'h024;
  localparam WN = 12'h028;
  reg clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0;
  reg [1:0] htr = 2'h0;
  reg [11:0] ha = 12'h000;
  reg [31:0] hwd = 32'h0, rd;
  wire rdy, mp, spi, ir, pe, po, two, nine, lsb, trl, lin, rld, abt, dn;
  wire ok, bsy, vld, hrsp;
  wire [1:0] md;
  wire [3:0] bits;
  wire [7:0] cnt;
  wire [15:0] baud;
  wire [31:0] hrd;
  integer bad_count = 0, tests_run = 0, cyc = 0, nr = 0, na = 0, nd = 0;
  integer i, j, t, c;
  ufb_frame_baud_cfg i_dut (.CLOCK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(ha), .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwd), .HREADY_IN(rdy), .HREADYOUT_OUT(rdy),
    .HRESP_OUT(hrsp),
    .HRDATA_OUT(hrd), .XFER_BUSY_IN(bsy), .PAIR_COUNT_VALID_IN(vld),
    .PAIR_COUNT_IN(cnt), .MULTIPROC_MODE_OUT(mp), .COMM_MODE_OUT(md),
    .HOST_SPI_MODE_OUT(spi), .INFRARED_MODE_OUT(ir),
    .PARITY_ENABLE_OUT(pe), .PARITY_ODD_OUT(po), .TWO_STOP_BITS_OUT(two),
    .DATA_BITS_OUT(bits), .NINE_BIT_HIGH_FIRST_OUT(nine),
    .SPI_LSB_FIRST_OUT(lsb), .SPI_SAMPLE_TRAILING_OUT(trl),
    .BAUD_PRESCALER_OUT(baud), .LIN_AUTOBAUD_OUT(lin),
    .BAUD_RELOAD_OUT(rld), .ORDER_ABORT_OUT(abt),
    .WINDOW_CHECK_DONE_OUT(dn), .WINDOW_OK_OUT(ok));
  ufb_peer_model i_peer (.clk_in(clk), .busy_out(bsy), .valid_out(vld),
    .count_out(cnt));
  initial forever #5 clk = ~clk;
  // pulse counters and the hang limit
  always @(posedge clk) begin
    nr <= nr + (rld === 1'b1);
    na <= na + (abt === 1'b1);
    nd <= nd + (dn === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task final_report;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // ready looked at just before the edge that samples it
  task rdy_wait;
    begin
      @(negedge clk);
      while (rdy !== 1'b1) @(negedge clk);
      rd = hrd;
      @(posedge clk);
    end
  endtask
  task bus(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      ha <= a;
      htr <= 2'h2;
      hwr <= wr;
      rdy_wait;
      htr <= 2'h0;
      hwd <= d;
      rdy_wait;
      hsel <= 1'b0;
      #1;
    end
  endtask
  task w(input [11:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task r(input [63:0] nm, input [11:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, rd, e);
      chk("resp", hrsp, 1'b0);
    end
  endtask
  task t_reset;
    begin
      r("frame", FR, 8'h03);
      r("rxctrl", RX, 8'h00);
      r("baud_lo", BL, 8'h00);
      r("baud_hi", BH, 8'h00);
      r("window", WN, 8'h00);
      r("unmap", 12'h02C, 8'h00);
      chk("bits", bits, 8);
    end
  endtask
  task t_modes;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        w(FR, i * 64 + 8'h3A);
        chk("mode", md, i);
        chk("ir", ir, i == 2);
        chk("spi", spi, 0);
        r("frame", FR, i * 64 + 8'h3A);
      end
      w(FR, 8'hFF);
      r("spifrm", FR, 8'hC6);
      chk("spi", spi, 1);
      chk("lsb", lsb, 1);
      chk("trail", trl, 1);
      w(FR, 8'hC0);
      chk("lsb", lsb, 0);
      chk("trail", trl, 0);
    end
  endtask
  task t_abort;
    begin
      c = na;
      i_peer.set_busy(1'b1);
      w(FR, 8'hC4);
      w(FR, 8'hC6);
      i_peer.set_busy(1'b0);
      w(FR, 8'hC2);
      r("frame", FR, 8'hC2);
      chk("aborts", na - c, 1);
    end
  endtask
  task t_fields;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        w(FR, i * 16 + (i % 2) * 8 + 3);
        chk("par_en", pe, i > 1);
        chk("par_odd", po, i == 3);
        chk("stop2", two, i % 2);
      end
      for (i = 0; i < 8; i = i + 1) begin
        w(FR, i);
        chk("bits", bits, i < 4 ? i + 5 : (i < 6 ? 8 : 9));
        chk("nine_hi", nine, i == 7);
      end
    end
  endtask
  task t_baud;
    begin
      c = nr;
      w(BL, 32'hFFFFFF5A);
      w(BH, 32'h000000A5);
      chk("baud", baud, 16'hA55A);
      r("baud_lo", BL, 8'h5A);
      r("baud_hi", BH, 8'hA5);
      chk("reloads", nr - c, 2);
    end
  endtask
  task t_window;
    begin
      w(RX, 8'h07);
      chk("mproc", mp, 1);
      chk("lin", lin, 1);
      c = nd;
      for (i = 0; i < 4; i = i + 1) begin
        w(WN, i * 64);
        t = i == 0 ? 6 : i == 1 ? 5 : i == 2 ? 7 : 8;
        for (j = 0; j < 4; j = j + 1) begin
          i_peer.send(j < 2 ? 31 - t + j : 30 + t + j);
          @(posedge clk);
          #1;
          chk("win_ok", ok, j == 1 || j == 2);
        end
      end
      w(RX, 8'h02);
      chk("mproc", mp, 0);
      i_peer.send(8'h20);
      @(posedge clk);
      #1;
      chk("checks", nd - c, 16);
    end
  endtask
  // reset again in mid-run: settings must return to their reset values
  task t_rerst;
    begin
      w(BL, 32'h00000033);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("baud", baud, 16'h0000);
      chk("lin", lin, 0);
      chk("spi", spi, 0);
      r("frame", FR, 8'h03);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_modes;
    t_abort;
    t_fields;
    t_baud;
    t_window;
    t_rerst;
    final_report;
  end
endmodule // ufb_frame_baud_cfg_test
